// ==== verilog/metrology_pkg.sv ====
// constants shared by the metrology accumulator and its sample fifo
// assumes one 100 MHz reference clock feeding every module
package metrology_pkg;
  // clock tree: reference, derived oscillator, modulator
  localparam int unsigned REF_HZ      = 100_000_000;
  localparam int unsigned OSC_HZ      = 16_000_000;
  localparam int unsigned MOD_HZ      = 1_048_576;
  localparam int unsigned MOD_EDGE_HZ = 2 * MOD_HZ; // two edges per modulator period
  localparam int unsigned OVERSAMPLING_RATIO         = 256;        // oversampling ratio, 4.096 ksps result
  localparam int unsigned EDGES_PER_SAMPLE = 2 * OVERSAMPLING_RATIO;
  // sample path
  localparam int unsigned SAMPLE_W  = 24;
  localparam int unsigned ACC_W     = 48;
  localparam int unsigned DC_FRAC   = 8;  // dc estimate carries extra fraction bits
  localparam int unsigned DC_SHIFT  = 10; // long time constant of the dc tracker
  localparam int unsigned DELAY_LEN = 32; // whole-sample voltage delay line depth
  localparam int unsigned FIFO_DEPTH = 8;
  // frame: 50 or 60 mains cycles; 4096/55 samples splits the two line rates
  localparam logic [11:0] PERIOD_SPLIT = 12'h04a;
  localparam logic [6:0]  CYCLES_50HZ  = 7'h32;
  localparam logic [6:0]  CYCLES_60HZ  = 7'h3c;
  localparam logic [11:0] PERIOD_RESET = 12'h052; // nominal 50 Hz period in samples
  // energy pulse width
  localparam int unsigned PULSE_US  = 10;
  localparam int unsigned PULSE_CYC = (PULSE_US * (REF_HZ / 1_000_000) > 0) ?
                                      PULSE_US * (REF_HZ / 1_000_000) : 1;
  // processing sequence, gray along the path
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CLEAN = 2'b01,
    ST_SHIFT = 2'b11,
    ST_ACC   = 2'b10
  } proc_state_t;
endpackage : metrology_pkg

// ==== verilog/sample_stream_if.sv ====
// valid/ready stream carrying one group of three converter samples
// assumes producer and consumer share ref_clk
`timescale 1ns/10ps
`default_nettype none
interface sample_stream_if #(parameter int unsigned WIDTH = 72);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface : sample_stream_if
`default_nettype wire

// ==== verilog/sample_fifo.sv ====
// small synchronous fifo between converter group and sample processing
// assumes one clock; full and ready come from flip-flops
`timescale 1ns/10ps
`default_nettype none
module sample_fifo #(
  parameter int unsigned WIDTH = 72,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             ref_clk,  // system clock
  input  wire logic             reset,    // synchronous, active high
  input  wire logic             in_valid, // producer offers a word
  input  wire logic [WIDTH-1:0] in_data,  // producer word
  output logic                  in_ready, // room for a word
  sample_stream_if.source       out       // drained side
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             push;
  logic             pop;

  // ************************************************
  // handshake and occupancy
  // ************************************************
  assign push = in_valid && in_ready;
  assign pop  = out.valid && out.ready;
  assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
  assign out.valid  = (count_reg != '0);
  assign out.data   = mem[rd_ptr_reg];

  // pointers wrap at the power-of-two depth
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      in_ready   <= 1'b0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      count_reg <= count_next;
      in_ready  <= (count_next != (AW+1)'(DEPTH)); // registered so the pin has no comb path
    end
  end

  // storage without reset, only written words are ever read
  always_ff @(posedge ref_clk) begin
    if (push) mem[wr_ptr_reg] <= in_data;
  end
endmodule : sample_fifo
`default_nettype wire

// ==== verilog/energy_metrology_accumulator.sv ====
// per-sample metrology datapath of a single-phase energy meter
// assumes the converter group runs on ref_clk and the consumer acks frames
`timescale 1ns/10ps
`default_nettype none
// Function
// - modulator clock 1048576 Hz, ratio 256, one sample per channel at 4.096 ksps
// - modulator clock divided down from a 16 MHz oscillator
// - every sampling instant raises an event starting the accumulation step
// - channel 0 voltage, 1 line current, 2 neutral current, common trigger
// - each event captures one voltage and two currents, processed before accumulation
// - separate 48-bit sums of v squared, i squared, v times i, shifted v times i
// - frame ends on a voltage cycle boundary after 50 or 60 cycles
// - a counter holds the number of samples in each frame
// - frame end sets a ready flag for the consumer
// - 90 degree shift is whole-sample delay plus fractional filter from mains period
// - power samples are phase corrected before accumulation
// - per-sample path also makes energy pulses and frequency measurement
// - samples are signed and a tracked dc estimate is subtracted
module energy_metrology_accumulator #(
  parameter logic [47:0] energy_threshold = 48'h0000_0100_0000
) (
  input  wire logic        ref_clk,         // 100 MHz system clock
  input  wire logic        reset,           // synchronous, active high
  input  wire logic        conv_valid,      // converter group delivers a sample set
  input  wire logic [23:0] voltage_sample,  // converter 0, signed
  input  wire logic [23:0] line_sample,     // converter 1, signed
  input  wire logic [23:0] neutral_sample,  // converter 2, signed
  input  wire logic [7:0]  phase_trim,      // signed current phase correction, 1/256 sample
  input  wire logic        frame_ack,       // consumer took the held frame
  output logic             mod_clk,         // modulator clock to converters
  output logic             sample_trigger,  // common conversion trigger pulse
  output logic             conv_ready,      // fifo has room
  output logic             frame_ready,     // held totals valid
  output logic [47:0]      hold_v_sq,       // sum of v squared
  output logic [47:0]      hold_i_sq,       // sum of line i squared
  output logic [47:0]      hold_in_sq,      // sum of neutral i squared
  output logic [47:0]      hold_active,     // sum of v times i
  output logic [47:0]      hold_reactive,   // sum of shifted v times i
  output logic [15:0]      hold_count,      // samples in held frame
  output logic [11:0]      cycle_period,    // mains period in samples
  output logic             energy_pulse     // energy-proportional pulse
);
  localparam int unsigned SW = metrology_pkg::SAMPLE_W;
  localparam int unsigned AW = metrology_pkg::ACC_W;

  // ************************************************
  // clock derivation
  // ************************************************
  logic [26:0] osc_acc_reg;
  logic        osc_tick_reg;
  logic [24:0] mod_acc_reg;
  logic        mod_edge_reg;
  logic [8:0]  edge_cnt_reg;

  // 16 MHz oscillator ticks from the reference by phase accumulation
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      osc_acc_reg  <= '0;
      osc_tick_reg <= 1'b0;
    end else if (osc_acc_reg + 27'(metrology_pkg::OSC_HZ) >= 27'(metrology_pkg::REF_HZ)) begin
      osc_acc_reg  <= osc_acc_reg + 27'(metrology_pkg::OSC_HZ) - 27'(metrology_pkg::REF_HZ);
      osc_tick_reg <= 1'b1;
    end else begin
      osc_acc_reg  <= osc_acc_reg + 27'(metrology_pkg::OSC_HZ);
      osc_tick_reg <= 1'b0;
    end
  end

  // modulator edges divided from oscillator ticks; ratio is not whole, so edges jitter by one tick
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mod_acc_reg  <= '0;
      mod_edge_reg <= 1'b0;
    end else if (osc_tick_reg) begin
      if (mod_acc_reg + 25'(metrology_pkg::MOD_EDGE_HZ) >= 25'(metrology_pkg::OSC_HZ)) begin
        mod_acc_reg  <= mod_acc_reg + 25'(metrology_pkg::MOD_EDGE_HZ) - 25'(metrology_pkg::OSC_HZ);
        mod_edge_reg <= 1'b1;
      end else begin
        mod_acc_reg  <= mod_acc_reg + 25'(metrology_pkg::MOD_EDGE_HZ);
        mod_edge_reg <= 1'b0;
      end
    end else begin
      mod_edge_reg <= 1'b0;
    end
  end

  // modulator clock and one trigger per oversampling window
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mod_clk        <= 1'b0;
      edge_cnt_reg   <= '0;
      sample_trigger <= 1'b0;
    end else begin
      sample_trigger <= 1'b0;
      if (mod_edge_reg) begin
        mod_clk <= !mod_clk;
        if (edge_cnt_reg == 9'(metrology_pkg::EDGES_PER_SAMPLE - 1)) begin
          edge_cnt_reg   <= '0;
          sample_trigger <= 1'b1;
        end else begin
          edge_cnt_reg <= edge_cnt_reg + 1'b1;
        end
      end
    end
  end

  // ************************************************
  // sample buffering
  // ************************************************
  sample_stream_if #(.WIDTH(3 * SW)) smp ();

  sample_fifo #(.WIDTH(3 * SW), .DEPTH(metrology_pkg::FIFO_DEPTH)) u_fifo (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .in_valid (conv_valid),
    .in_data  ({neutral_sample, line_sample, voltage_sample}),
    .in_ready (conv_ready),
    .out      (smp)
  );

  // ************************************************
  // per-sample sequence
  // ************************************************
  metrology_pkg::proc_state_t state_reg;
  logic signed [SW-1:0] raw_reg [3];
  logic signed [31:0]   dc_reg  [3];
  logic signed [SW-1:0] cln_reg [3];
  logic signed [SW-1:0] vdl_reg [metrology_pkg::DELAY_LEN];
  logic signed [SW-1:0] iprev_reg;
  logic signed [SW-1:0] icor_reg;
  logic                 zc_reg;
  logic [11:0]          since_zc_reg;
  logic [6:0]           cycles_reg;
  logic [15:0]          count_reg;
  logic [AW-1:0]        acc_reg  [5];
  logic [AW-1:0]        term     [5];
  logic [AW-1:0]        acc_next [5];
  logic signed [SW-1:0] v90;
  logic signed [SW+8:0] v_step;
  logic signed [SW+8:0] i_step;
  logic [4:0]           q_int;
  logic [7:0]           q_frac;
  logic [6:0]           cycle_target;
  logic                 frame_end;

  assign smp.ready = (state_reg == metrology_pkg::ST_IDLE);

  // sequence: take a set, clean it, shift it, accumulate it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg <= metrology_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        metrology_pkg::ST_IDLE: begin
          if (smp.valid) state_reg <= metrology_pkg::ST_CLEAN;
        end
        metrology_pkg::ST_CLEAN: state_reg <= metrology_pkg::ST_SHIFT;
        metrology_pkg::ST_SHIFT: state_reg <= metrology_pkg::ST_ACC;
        metrology_pkg::ST_ACC:   state_reg <= metrology_pkg::ST_IDLE;
        default:                 state_reg <= metrology_pkg::ST_IDLE;
      endcase
    end
  end

  // per-channel capture and dc removal
  generate
    for (genvar c = 0; c < 3; c++) begin : g_chan
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          raw_reg[c] <= '0;
          dc_reg[c]  <= '0;
          cln_reg[c] <= '0;
        end else if (state_reg == metrology_pkg::ST_IDLE && smp.valid) begin
          raw_reg[c] <= smp.data[c*SW +: SW];
        end else if (state_reg == metrology_pkg::ST_CLEAN) begin
          // slow first-order tracker; a step in offset takes thousands of samples to settle
          dc_reg[c]  <= dc_reg[c] + (((32'(raw_reg[c]) <<< metrology_pkg::DC_FRAC) - dc_reg[c])
                        >>> metrology_pkg::DC_SHIFT);
          cln_reg[c] <= raw_reg[c] - SW'(dc_reg[c] >>> metrology_pkg::DC_FRAC);
        end
      end
    end
  endgenerate

  // current phase trim by interpolation toward the previous sample
  assign i_step = (33'(cln_reg[1]) - 33'(iprev_reg)) * 33'($signed(phase_trim));

  // voltage delay line, cycle detection and period measurement
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int k = 0; k < metrology_pkg::DELAY_LEN; k++) vdl_reg[k] <= '0;
      iprev_reg    <= '0;
      icor_reg     <= '0;
      zc_reg       <= 1'b0;
      since_zc_reg <= '0;
      cycle_period <= metrology_pkg::PERIOD_RESET;
    end else if (state_reg == metrology_pkg::ST_SHIFT) begin
      vdl_reg[0] <= cln_reg[0];
      for (int k = 1; k < metrology_pkg::DELAY_LEN; k++) vdl_reg[k] <= vdl_reg[k-1];
      iprev_reg <= cln_reg[1];
      icor_reg  <= cln_reg[1] - SW'(i_step >>> 8);
      // rising crossing of the voltage closes one mains cycle
      zc_reg    <= vdl_reg[0][SW-1] && !cln_reg[0][SW-1];
      if (vdl_reg[0][SW-1] && !cln_reg[0][SW-1]) begin
        cycle_period <= since_zc_reg + 1'b1;
        since_zc_reg <= '0;
      end else if (since_zc_reg != 12'hfff) begin
        since_zc_reg <= since_zc_reg + 1'b1;
      end
    end
  end

  // quarter period: whole samples and 1/256 fraction; a period of 124 samples or more (mains below about 33 Hz) saturates the line
  assign q_int  = (cycle_period[11:2] > 10'(metrology_pkg::DELAY_LEN - 2)) ?
                  5'(metrology_pkg::DELAY_LEN - 2) : cycle_period[6:2];
  assign q_frac = {cycle_period[1:0], 6'h00};
  assign v_step = (33'(vdl_reg[q_int + 5'h01]) - 33'(vdl_reg[q_int])) * 33'({1'b0, q_frac});
  assign v90    = vdl_reg[q_int] + SW'(v_step >>> 8);

  // products and squares sign-extended to the sum width
  assign term[0] = AW'(vdl_reg[0]) * AW'(vdl_reg[0]);
  assign term[1] = AW'(icor_reg) * AW'(icor_reg);
  assign term[2] = AW'(cln_reg[2]) * AW'(cln_reg[2]);
  assign term[3] = AW'(vdl_reg[0]) * AW'(icor_reg);
  assign term[4] = AW'(v90) * AW'(icor_reg);

  assign cycle_target = (cycle_period < metrology_pkg::PERIOD_SPLIT) ?
                        metrology_pkg::CYCLES_60HZ : metrology_pkg::CYCLES_50HZ;
  assign frame_end    = (state_reg == metrology_pkg::ST_ACC) && zc_reg &&
                        (cycles_reg + 1'b1 == cycle_target);

  // five sums; the closing sample belongs to the frame it ends
  generate
    for (genvar a = 0; a < 5; a++) begin : g_acc
      assign acc_next[a] = acc_reg[a] + term[a];
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          acc_reg[a] <= '0;
        end else if (frame_end) begin
          acc_reg[a] <= '0;
        end else if (state_reg == metrology_pkg::ST_ACC) begin
          acc_reg[a] <= acc_next[a];
        end
      end
    end
  endgenerate

  // cycle and sample counters
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cycles_reg <= '0;
      count_reg  <= '0;
    end else if (frame_end) begin
      cycles_reg <= '0;
      count_reg  <= '0;
    end else if (state_reg == metrology_pkg::ST_ACC) begin
      count_reg <= count_reg + 1'b1;
      if (zc_reg) cycles_reg <= cycles_reg + 1'b1;
    end
  end

  // holding registers, loaded in the same cycle the sums clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hold_v_sq     <= '0;
      hold_i_sq     <= '0;
      hold_in_sq    <= '0;
      hold_active   <= '0;
      hold_reactive <= '0;
      hold_count    <= '0;
    end else if (frame_end) begin
      hold_v_sq     <= acc_next[0];
      hold_i_sq     <= acc_next[1];
      hold_in_sq    <= acc_next[2];
      hold_active   <= acc_next[3];
      hold_reactive <= acc_next[4];
      hold_count    <= count_reg + 1'b1;
    end
  end

  // ready flag: a new frame beats an ack in the same cycle
  always_ff @(posedge ref_clk) begin
    if (reset) frame_ready <= 1'b0;
    else if (frame_end) frame_ready <= 1'b1;
    else if (frame_ack) frame_ready <= 1'b0;
  end

  // ************************************************
  // energy pulses
  // ************************************************
  logic [AW-1:0] energy_reg;
  logic [AW-1:0] energy_sum;
  logic [15:0]   pulse_cnt_reg;

  // only delivered energy counts; residue above threshold is kept to avoid jitter
  assign energy_sum = energy_reg + (term[3][AW-1] ? '0 : term[3]);
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      energy_reg    <= '0;
      pulse_cnt_reg <= '0;
      energy_pulse  <= 1'b0;
    end else begin
      if (state_reg == metrology_pkg::ST_ACC) begin
        if (energy_sum >= energy_threshold) begin
          energy_reg    <= energy_sum - energy_threshold;
          pulse_cnt_reg <= 16'(metrology_pkg::PULSE_CYC);
        end else begin
          energy_reg <= energy_sum;
        end
      end
      // width counts every clock; only a fresh crossing reloads it
      if (pulse_cnt_reg != '0 && !(state_reg == metrology_pkg::ST_ACC && energy_sum >= energy_threshold)) begin
        pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
      end
      energy_pulse <= (pulse_cnt_reg != '0);
    end
  end

  // ************************************************
  // assertions
  // ************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  property p_trigger_spacing;
    sample_trigger |=> !sample_trigger [*8];
  endproperty
  a_trigger_spacing: assert property (p_trigger_spacing) else $error("trigger repeated too soon");

  property p_mod_on_tick;
    mod_edge_reg |-> $past(osc_tick_reg);
  endproperty
  a_mod_on_tick: assert property (p_mod_on_tick) else $error("modulator edge without oscillator tick");

  property p_sequence;
    (state_reg == metrology_pkg::ST_IDLE && smp.valid) |=> state_reg == metrology_pkg::ST_CLEAN
      ##1 state_reg == metrology_pkg::ST_SHIFT ##1 state_reg == metrology_pkg::ST_ACC;
  endproperty
  a_sequence: assert property (p_sequence) else $error("sample set not processed in order");

  property p_dc_removed;
    state_reg == metrology_pkg::ST_CLEAN |=>
      cln_reg[0] == $past(raw_reg[0]) - SW'($past(dc_reg[0]) >>> metrology_pkg::DC_FRAC);
  endproperty
  a_dc_removed: assert property (p_dc_removed) else $error("dc estimate not subtracted");

  property p_accumulate;
    (state_reg == metrology_pkg::ST_ACC && !frame_end) |=> acc_reg[4] == $past(acc_reg[4]) + $past(term[4]);
  endproperty
  a_accumulate: assert property (p_accumulate) else $error("reactive sum not updated");

  property p_count;
    (state_reg == metrology_pkg::ST_ACC && !frame_end) |=> count_reg == $past(count_reg) + 16'h0001;
  endproperty
  a_count: assert property (p_count) else $error("sample count not advanced");

  property p_frame_boundary;
    frame_end |-> zc_reg && cycles_reg == cycle_target - 7'h01;
  endproperty
  a_frame_boundary: assert property (p_frame_boundary) else $error("frame closed off a cycle boundary");

  property p_hold_clear;
    frame_end |=> acc_reg[0] == '0 && count_reg == '0 && hold_count == $past(count_reg) + 16'h0001
      && hold_active == $past(acc_next[3]) && frame_ready;
  endproperty
  a_hold_clear: assert property (p_hold_clear) else $error("frame not held and cleared together");

  property p_ready_stays;
    (frame_ready && !frame_ack) |=> frame_ready;
  endproperty
  a_ready_stays: assert property (p_ready_stays) else $error("frame ready dropped without ack");
endmodule : energy_metrology_accumulator
`default_nettype wire

// ==== tb/converter_group_model.sv ====
// three converter channels feeding the metrology accumulator
// assumes ref_clk is shared with the design; square wave voltage
`timescale 1ns/10ps
`default_nettype none
module converter_group_model #(
  parameter int unsigned HALF = 20,          // samples per half cycle
  parameter logic [23:0] AMP  = 24'h000400   // wave amplitude
) (
  input  wire logic        ref_clk,        // system clock
  input  wire logic        run,            // offer sample sets
  input  wire logic        i_neg,          // current in antiphase
  input  wire logic        conv_ready,     // fifo has room
  output logic             conv_valid,     // set offered
  output logic [23:0]      voltage_sample, // channel 0
  output logic [23:0]      line_sample,    // channel 1
  output logic [23:0]      neutral_sample  // channel 2
);
  logic [7:0]  pos_reg  = 8'h00;
  logic        high_reg = 1'b0;
  logic        high_next;
  logic [23:0] v_next;
  // the wave advances only on a taken set, so a refused set is offered again
  always_comb begin
    high_next = (conv_valid && conv_ready && pos_reg == 8'(HALF - 1)) ? ~high_reg : high_reg;
    v_next = high_next ? AMP : -AMP; // signed samples
  end
  initial begin
    conv_valid = 1'b0;
    voltage_sample = 24'h000000;
    line_sample = 24'h000000;
    neutral_sample = 24'h000000;
  end
  // idle lines toggle so stale data is never mistaken for a sample
  always @(posedge ref_clk) begin
    if (conv_valid && conv_ready) begin
      pos_reg <= (pos_reg == 8'(HALF - 1)) ? 8'h00 : pos_reg + 8'h01;
      high_reg <= high_next;
    end
    conv_valid <= run; // one voltage and two currents per set
    voltage_sample <= run ? v_next : ~voltage_sample;
    line_sample <= run ? (i_neg ? -v_next : v_next) : ~line_sample;
    neutral_sample <= run ? v_next : ~neutral_sample;
  end
endmodule : converter_group_model
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the metrology accumulator
// assumes the converter model is the only sample source
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic ref_clk = 1'b0, reset = 1'b1, run = 1'b0, i_neg = 1'b0, frame_ack = 1'b0, saw_full = 1'b0;
  wire logic cv, cr, mod_clk, trig, fr, pulse;
  wire logic [23:0] vs, ls, ns;
  wire logic [47:0] v_sq, i_sq, in_sq, act, react;
  wire logic [15:0] cnt;
  wire logic [11:0] period;
  int n_mismatch = 0, comparisons = 0, pulses = 0, width = 0, rises = 0, e0;
  time t0;
  logic trig_done = 1'b0;
  logic [47:0] mag;
  typedef struct {logic neg; logic act_neg; logic pulse;} row_t;
  row_t rows [2] = '{'{1'b0, 1'b0, 1'b1}, '{1'b1, 1'b1, 1'b0}};
  always #5 ref_clk = ~ref_clk;
  converter_group_model converter_group_model_inst (.ref_clk(ref_clk), .run(run), .i_neg(i_neg),
    .conv_ready(cr), .conv_valid(cv), .voltage_sample(vs), .line_sample(ls), .neutral_sample(ns));
  energy_metrology_accumulator #(.energy_threshold(48'h0000_4000_0000)) energy_metrology_accumulator_inst (
    .ref_clk(ref_clk), .reset(reset), .conv_valid(cv), .voltage_sample(vs), .line_sample(ls),
    .neutral_sample(ns), .phase_trim(8'h00), .frame_ack(frame_ack), .mod_clk(mod_clk),
    .sample_trigger(trig), .conv_ready(cr), .frame_ready(fr), .hold_v_sq(v_sq), .hold_i_sq(i_sq),
    .hold_in_sq(in_sq), .hold_active(act), .hold_reactive(react), .hold_count(cnt),
    .cycle_period(period), .energy_pulse(pulse));
  task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cmp_range(input logic [47:0] got, input logic [47:0] lo, input logic [47:0] hi);
    comparisons++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask : cmp_range
  task automatic summarize;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  // bounded wait for a frame, then acknowledge it
  task automatic wait_frame;
    int k;
    k = 0;
    while (fr !== 1'b1 && k < 20000) begin
      @(posedge ref_clk);
      #1 k++;
    end
    cmp(fr, 1'b1);
    @(posedge ref_clk) frame_ack <= 1'b1;
    @(posedge ref_clk) frame_ack <= 1'b0;
    #1 cmp(fr, 1'b0);
  endtask : wait_frame
  // pulse widths and fifo back-pressure are watched all run long
  always @(posedge ref_clk) begin
    if (run && cr === 1'b0) saw_full = 1'b1;
    if (pulse === 1'b1) width++;
    else if (width > 0) begin
      cmp_range(width, 1000, 1010);
      pulses++;
      width = 0;
    end
  end
  always @(posedge mod_clk) rises++;
  initial begin
    wait (!reset);
    @(posedge trig) e0 = rises;
    t0 = $time;
    @(posedge trig) cmp(rises - e0, 256);
    cmp_range(($time - t0) / 10, 24400, 24430);
    trig_done = 1'b1;
  end
  initial begin
    #1_000_000 n_mismatch++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    #1 cmp(cr, 1'b0);
    cmp(period, 12'h052);
    cmp(fr, 1'b0);
    @(posedge ref_clk) reset <= 1'b0;
    run <= 1'b1;
    // first frame of each row mixes old and new stimulus and is discarded
    foreach (rows[r]) begin
      i_neg <= rows[r].neg;
      wait_frame();
      pulses = 0;
      wait_frame();
      cmp(cnt, 16'h0960);
      cmp(period, 12'h028);
      cmp(act[47], rows[r].act_neg);
      cmp(pulses > 0, rows[r].pulse);
      cmp(in_sq, v_sq);
      // consumer view: mean square and mean product near the squared amplitude, reactive near zero
      mag = rows[r].act_neg ? -act : act;
      cmp_range(v_sq / cnt, 48'h0f_8000, 48'h10_8000);
      cmp_range(mag / cnt, 48'h0f_8000, 48'h10_8000);
      cmp_range(react[47] ? -react : react, 48'h0, v_sq >> 4);
      cmp_range((mag / cnt) * cnt, 48'h9150_0000, 48'h9ab0_0000);
    end
    // the trigger spacing check spans two sample periods and must finish first
    wait (trig_done);
    cmp(saw_full, 1'b1);
    run <= 1'b0;
    repeat (40) @(posedge ref_clk);
    #1 cmp(cr, 1'b1);
    run <= 1'b1;
    repeat (300) @(posedge ref_clk);
    reset <= 1'b1;
    repeat (10) @(posedge ref_clk);
    #1 cmp(fr, 1'b0);
    cmp(cnt, 16'h0000);
    cmp(period, 12'h052);
    cmp(pulse, 1'b0);
    summarize();
  end
endmodule : testbench
`default_nettype wire
